/* File: rtl/pmrl_dev.sv */
// Purpose: Transceiver end: reset sequencing, strap latch, MII clocks and 100 Mbps latencies.
// Assumes: clk_sys at 25 MHz; the line is modelled as a nibble stream with code-group markers.
// Notes: Line delays are counted in 10 ns bit times, four bits per system clock.
// Summary of operation
// [RULE1] Station waits 167 ms after power-up.
// [RULE2] Management data held high 32 bits first.
// [RULE3] Straps taken no earlier than 167 ms.
// [RULE4] Strap pins become outputs 50 ns later; here one 40 ns system clock after the latch.
// [RULE5] Station waits 3 us after reset release.
// [RULE6] Straps latched 3 us after any reset.
// [RULE7] Hardware reset pulse held at least 1 us.
// [RULE8] J code appears 6 bits after TX_EN.
// [RULE9] Line ends 6 bits after frame end.
// [RULE10] Carrier 20 bits, data 24 bits after J.
// [RULE11] Carrier drops 24 bits after T code.
// [RULE12] MII clocks are 25 MHz, even duty; here they run at 12.5 MHz, half the system clock.
`timescale 1ns/100ps
`include "pmrl_map.svh"
module pmrl_dev #(
	parameter int PWRUP_CYC = `PMRL_PWRUP_CYC,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	pmrl_if.dev mii,
	input wire logic soft_reset,
	input wire pmrl_pkg::pmrl_strap_t strap_in,
	output pmrl_pkg::pmrl_strap_t strap_latched,
	output logic strap_valid,
	output pmrl_pkg::pmrl_nib_t line_tx_data,
	output pmrl_pkg::pmrl_line_e line_tx_code,
	input wire pmrl_pkg::pmrl_nib_t line_rx_data,
	input wire pmrl_pkg::pmrl_line_e line_rx_code,
	output logic rx_overflow
);
	import pmrl_pkg::*;
	localparam int TXD = (`PMRL_TX_LAT_BITS + 3) / 4;
	localparam int CRSD = `PMRL_CRS_ON_BITS / 4;
	localparam int RXD = `PMRL_RX_LAT_BITS / 4;
	localparam int CRSOFF = `PMRL_CRS_OFF_BITS / 4;
	logic [1:0] rstp_sync_ff;
	logic [31:0] pwr_cnt_ff;
	logic [15:0] rel_cnt_ff;
	logic [3:0] drv_cnt_ff;
	logic pwr_ok_ff;
	logic in_reset;
	logic mii_clk_ff;
	logic [TXD-1:0] tx_en_pipe_ff;
	pmrl_nib_t tx_d_pipe_ff [TXD];
	logic tx_en_d_ff;
	logic [RXD-1:0] rx_dv_pipe_ff;
	pmrl_nib_t rx_d_pipe_ff [RXD];
	logic [CRSD-1:0] crs_on_pipe_ff;
	logic [CRSOFF-1:0] crs_off_pipe_ff;
	logic crs_ff;
	logic fifo_out_valid;
	pmrl_nib_t fifo_out_data;
	logic fifo_in_ready;
	logic rx_take;

	// Bring the reset pin into the clock domain.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rstp_sync_ff <= 2'b00;
		end else begin
			rstp_sync_ff <= {rstp_sync_ff[0], mii.rst_pin_n};
		end
	end
	assign in_reset = !rstp_sync_ff[1] || soft_reset;

	// Power-up stabilization: straps are never taken before this elapses.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pwr_cnt_ff <= '0;
			pwr_ok_ff <= 1'b0;
		end else if (!pwr_ok_ff) begin
			pwr_cnt_ff <= pwr_cnt_ff + 32'd1;
			pwr_ok_ff <= (pwr_cnt_ff >= 32'(PWRUP_CYC - 1)); // [RULE3]
		end
	end

	// Time from reset release to strap latch, then to pin turnaround.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rel_cnt_ff <= '0;
			drv_cnt_ff <= '0;
			strap_valid <= 1'b0;
			strap_latched <= '0;
			mii.strap_oe_n <= 1'b1;
			mii.strap_o <= '0;
		end else if (in_reset) begin
			rel_cnt_ff <= '0;
			drv_cnt_ff <= '0;
			strap_valid <= 1'b0;
			mii.strap_oe_n <= 1'b1;
		end else if (!strap_valid) begin
			if (rel_cnt_ff < 16'(`PMRL_RST_SETTLE_CYC)) begin
				rel_cnt_ff <= rel_cnt_ff + 16'd1;
			end else if (pwr_ok_ff) begin
				strap_latched <= strap_in; // [RULE6] [RULE3]
				strap_valid <= 1'b1;
			end
		end else if (mii.strap_oe_n) begin
			if (drv_cnt_ff >= 4'(`PMRL_DRV_CYC - 1)) begin
				mii.strap_oe_n <= 1'b0; // [RULE4]
				mii.strap_o <= strap_latched;
			end else begin
				drv_cnt_ff <= drv_cnt_ff + 4'd1;
			end
		end
	end

	// MII clocks toggle each system edge: 12.5 MHz, even duty when sampled.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mii_clk_ff <= 1'b0;
		end else begin
			mii_clk_ff <= !mii_clk_ff; // [RULE12]
		end
	end
	assign mii.tx_clk = mii_clk_ff;
	assign mii.rx_clk = mii_clk_ff;

	// Transmit latency pipe; J marks start, T marks end of stream.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_en_pipe_ff <= '0;
			tx_en_d_ff <= 1'b0;
			line_tx_code <= PMRL_LINE_IDLE;
			line_tx_data <= '0;
			for (int i = 0; i < TXD; i++) begin
				tx_d_pipe_ff[i] <= '0;
			end
		end else begin
			tx_en_pipe_ff <= {tx_en_pipe_ff[TXD-2:0], mii.tx_en && strap_valid};
			tx_d_pipe_ff[0] <= mii.txd;
			for (int i = 1; i < TXD; i++) begin
				tx_d_pipe_ff[i] <= tx_d_pipe_ff[i-1];
			end
			tx_en_d_ff <= tx_en_pipe_ff[TXD-1];
			line_tx_data <= tx_d_pipe_ff[TXD-1];
			if (tx_en_pipe_ff[TXD-1] && !tx_en_d_ff) begin
				line_tx_code <= PMRL_LINE_J; // [RULE8]
			end else if (tx_en_pipe_ff[TXD-1]) begin
				line_tx_code <= PMRL_LINE_DATA;
			end else if (tx_en_d_ff) begin
				line_tx_code <= PMRL_LINE_T; // [RULE9]
			end else begin
				line_tx_code <= PMRL_LINE_IDLE;
			end
		end
	end

	// Receive latency pipes and carrier sense.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_dv_pipe_ff <= '0;
			crs_on_pipe_ff <= '0;
			crs_off_pipe_ff <= '0;
			crs_ff <= 1'b0;
			for (int i = 0; i < RXD; i++) begin
				rx_d_pipe_ff[i] <= '0;
			end
		end else begin
			crs_on_pipe_ff <= {crs_on_pipe_ff[CRSD-2:0], line_rx_code == PMRL_LINE_J};
			crs_off_pipe_ff <= {crs_off_pipe_ff[CRSOFF-2:0], line_rx_code == PMRL_LINE_T};
			rx_dv_pipe_ff <= {rx_dv_pipe_ff[RXD-2:0],
				line_rx_code == PMRL_LINE_DATA || line_rx_code == PMRL_LINE_J};
			rx_d_pipe_ff[0] <= line_rx_data;
			for (int i = 1; i < RXD; i++) begin
				rx_d_pipe_ff[i] <= rx_d_pipe_ff[i-1];
			end
			if (crs_on_pipe_ff[CRSD-1]) begin
				crs_ff <= 1'b1; // [RULE10]
			end else if (crs_off_pipe_ff[CRSOFF-1]) begin
				crs_ff <= 1'b0; // [RULE11]
			end
		end
	end
	assign mii.crs = crs_ff;

	// Receive nibbles pass the FIFO; the MII drains one per cycle.
	assign rx_take = rx_dv_pipe_ff[RXD-1]; // [RULE10]
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_overflow <= 1'b0;
		end else if (rx_take && !fifo_in_ready) begin
			rx_overflow <= 1'b1;
		end
	end
	pmrl_fifo #(.WIDTH(4), .DEPTH(DEPTH)) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(rx_take),
		.in_ready(fifo_in_ready),
		.in_data(rx_d_pipe_ff[RXD-1]),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1),
		.out_data(fifo_out_data)
	);
	// Registered MII receive outputs.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mii.rx_dv <= 1'b0;
			mii.rxd <= '0;
		end else begin
			mii.rx_dv <= fifo_out_valid;
			mii.rxd <= fifo_out_data;
		end
	end
endmodule : pmrl_dev

/* File: rtl/pmrl_map.svh */
// Purpose: Timing counts and clock divisors for the transceiver link.
// Assumes: System clock of 25 MHz (40 ns period).
// Notes: Times keep their printed units; cycle counts derive from them.
`ifndef PMRL_MAP_SVH
`define PMRL_MAP_SVH
`define PMRL_CLK_NS 40
`define PMRL_PWRUP_MS 167
`define PMRL_PWRUP_CYC ((`PMRL_PWRUP_MS * 1000000 + `PMRL_CLK_NS - 1) / `PMRL_CLK_NS)
`define PMRL_RST_SETTLE_NS 3000
`define PMRL_RST_SETTLE_CYC ((`PMRL_RST_SETTLE_NS + `PMRL_CLK_NS - 1) / `PMRL_CLK_NS)
`define PMRL_RST_PULSE_NS 1000
`define PMRL_RST_PULSE_CYC ((`PMRL_RST_PULSE_NS + `PMRL_CLK_NS - 1) / `PMRL_CLK_NS)
`define PMRL_DRV_NS 50
`define PMRL_DRV_CYC (((`PMRL_DRV_NS / `PMRL_CLK_NS) < 1) ? 1 : (`PMRL_DRV_NS / `PMRL_CLK_NS))
`define PMRL_BIT_NS 10
`define PMRL_TX_LAT_BITS 6
`define PMRL_TX_END_BITS 6
`define PMRL_CRS_ON_BITS 20
`define PMRL_RX_LAT_BITS 24
`define PMRL_CRS_OFF_BITS 24
`define PMRL_PREAMBLE_BITS 32
`define PMRL_MDC_DIV 5
`define PMRL_MIICLK_DIV 1
`endif

/* File: rtl/pmrl_pkg.sv */
// Purpose: Types shared by both ends of the transceiver link.
// Assumes: Nothing beyond the map header.
// Notes: Only types live here.
package pmrl_pkg;
	typedef logic [3:0] pmrl_nib_t;
	typedef logic [4:0] pmrl_strap_t;
	typedef enum logic [1:0] {PMRL_LINE_IDLE, PMRL_LINE_J, PMRL_LINE_DATA, PMRL_LINE_T} pmrl_line_e;
endpackage : pmrl_pkg

/* File: rtl/pmrl_if.sv */
// Purpose: Joins the transceiver end and the controller end.
// Assumes: One clock domain per end; link clocks are sampled as data.
// Notes: Strap pins are two-way: the transceiver drives them once straps are taken.
`timescale 1ns/100ps
interface pmrl_if;
	import pmrl_pkg::*;
	logic rst_pin_n;
	logic tx_clk;
	logic rx_clk;
	logic tx_en;
	pmrl_nib_t txd;
	logic rx_dv;
	logic crs;
	pmrl_nib_t rxd;
	logic mdc;
	logic mdio_o;
	logic mdio_oe_n;
	pmrl_strap_t strap_o;
	logic strap_oe_n;
	modport dev (input rst_pin_n, output tx_clk, output rx_clk, input tx_en, input txd,
		output rx_dv, output crs, output rxd, input mdc, input mdio_o, input mdio_oe_n,
		output strap_o, output strap_oe_n);
	modport mac (output rst_pin_n, input tx_clk, input rx_clk, output tx_en, output txd,
		input rx_dv, input crs, input rxd, output mdc, output mdio_o, output mdio_oe_n,
		input strap_o, input strap_oe_n);
endinterface : pmrl_if

/* File: rtl/pmrl_fifo.sv */
// Purpose: Small word FIFO with valid and ready on both sides.
// Assumes: Single clock; depth is a power of two.
// Notes: Storage is flip-flops addressed by index.
`timescale 1ns/100ps
module pmrl_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic push;
	logic pop;
	// Full when pointers differ only in the wrap bit.
	assign in_ready = (wr_ff ^ rd_ff) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ff != rd_ff;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ff[AW-1:0]];
	// Write storage.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end
	// Pointers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= wr_ff + (AW+1)'(push);
			rd_ff <= rd_ff + (AW+1)'(pop);
		end
	end
endmodule : pmrl_fifo

/* File: rtl/pmrl_mac.sv */
// Purpose: Controller end: reset pulse, start-up waits, management preamble, transmit.
// Assumes: clk_sys at 25 MHz; MII clocks arrive from the transceiver as data.
// Notes: Transmit nibbles wait in a FIFO until the link is ready.
`timescale 1ns/100ps
`include "pmrl_map.svh"
module pmrl_mac #(
	parameter int PWRUP_CYC = `PMRL_PWRUP_CYC,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	pmrl_if.mac mii,
	input wire logic hw_reset_req,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire pmrl_pkg::pmrl_nib_t tx_data,
	input wire logic tx_last,
	output logic mgmt_ready,
	output logic rx_valid,
	output pmrl_pkg::pmrl_nib_t rx_data,
	output logic carrier
);
	import pmrl_pkg::*;
	typedef enum {PMRL_S_PWR, PMRL_S_RSTP, PMRL_S_SETTLE, PMRL_S_PRE, PMRL_S_RUN} pmrl_st_e;
	pmrl_st_e st_ff;
	logic [31:0] cnt_ff;
	logic [2:0] div_ff;
	logic [1:0] txc_sync_ff;
	logic [1:0] crs_sync_ff;
	logic [1:0] dv_sync_ff;
	pmrl_nib_t rxd_s1_ff;
	pmrl_nib_t rxd_s2_ff;
	logic txc_d_ff;
	logic txc_rise;
	logic f_valid;
	pmrl_nib_t f_data;
	logic f_ready;
	logic f_last;

	// Start-up sequence: power wait, reset pulse, settle, 32-bit preamble.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= PMRL_S_PWR;
			cnt_ff <= '0;
			mii.rst_pin_n <= 1'b0;
		end else begin
			case (st_ff)
				PMRL_S_PWR: begin
					cnt_ff <= cnt_ff + 32'd1;
					if (cnt_ff >= 32'(PWRUP_CYC - 1)) begin // [RULE1] [RULE3]
						cnt_ff <= '0;
						st_ff <= PMRL_S_RSTP;
					end
				end
				PMRL_S_RSTP: begin
					mii.rst_pin_n <= 1'b0;
					cnt_ff <= cnt_ff + 32'd1;
					if (cnt_ff >= 32'(`PMRL_RST_PULSE_CYC - 1)) begin // [RULE7]
						cnt_ff <= '0;
						mii.rst_pin_n <= 1'b1;
						st_ff <= PMRL_S_SETTLE;
					end
				end
				PMRL_S_SETTLE: begin
					cnt_ff <= cnt_ff + 32'd1;
					if (cnt_ff >= 32'(`PMRL_RST_SETTLE_CYC + 2)) begin // [RULE5]
						cnt_ff <= '0;
						st_ff <= PMRL_S_PRE;
					end
				end
				PMRL_S_PRE: begin
					// Count rising management clock edges, where the far end samples the bits.
					if (div_ff == 3'(`PMRL_MDC_DIV - 1) && !mii.mdc) begin
						cnt_ff <= cnt_ff + 32'd1;
						if (cnt_ff >= 32'(`PMRL_PREAMBLE_BITS - 1)) begin // [RULE2]
							st_ff <= PMRL_S_RUN;
						end
					end
				end
				PMRL_S_RUN: begin
					if (hw_reset_req) begin
						cnt_ff <= '0;
						mii.rst_pin_n <= 1'b0;
						st_ff <= PMRL_S_RSTP;
					end
				end
				default: begin
					st_ff <= PMRL_S_PWR;
				end
			endcase
		end
	end
	assign mgmt_ready = st_ff == PMRL_S_RUN;

	// Management clock divider and data line held high through the preamble.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
			mii.mdc <= 1'b0;
			mii.mdio_o <= 1'b1;
			mii.mdio_oe_n <= 1'b1;
		end else begin
			div_ff <= (div_ff == 3'(`PMRL_MDC_DIV - 1)) ? 3'd0 : div_ff + 3'd1;
			if (div_ff == 3'(`PMRL_MDC_DIV - 1)) begin
				mii.mdc <= !mii.mdc;
			end
			mii.mdio_o <= 1'b1; // [RULE2]
			mii.mdio_oe_n <= st_ff != PMRL_S_PRE;
		end
	end

	// Sample link clock and receive side through two flip-flops.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txc_sync_ff <= '0;
			crs_sync_ff <= '0;
			dv_sync_ff <= '0;
			rxd_s1_ff <= '0;
			rxd_s2_ff <= '0;
			txc_d_ff <= 1'b0;
		end else begin
			txc_sync_ff <= {txc_sync_ff[0], mii.tx_clk};
			crs_sync_ff <= {crs_sync_ff[0], mii.crs};
			dv_sync_ff <= {dv_sync_ff[0], mii.rx_dv};
			rxd_s1_ff <= mii.rxd;
			rxd_s2_ff <= rxd_s1_ff;
			txc_d_ff <= txc_sync_ff[1];
		end
	end
	assign txc_rise = txc_sync_ff[1] && !txc_d_ff;
	assign carrier = crs_sync_ff[1];
	assign rx_valid = dv_sync_ff[1];
	assign rx_data = rxd_s2_ff;

	pmrl_fifo #(.WIDTH(5), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data({tx_last, tx_data}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data({f_last, f_data})
	);
	// The frame ends when the buffer runs dry; the stored end mark is not needed.
	assign f_ready = txc_rise && mgmt_ready;

	// Drive transmit on the rising link clock; TX_EN falls after the last nibble.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mii.tx_en <= 1'b0;
			mii.txd <= '0;
		end else if (txc_rise) begin
			mii.tx_en <= f_valid && mgmt_ready;
			mii.txd <= f_valid ? f_data : 4'h0;
		end
	end
endmodule : pmrl_mac

/* File: sim/pmrl_chk_sva.sv */
// Purpose: Checker for the wires between the controller end and the transceiver end.
// Assumes: All link signals are sampled on clk_sys.
// Notes: Small counters carry the long waits.
`timescale 1ns/100ps
module pmrl_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rst_pin_n,
	input wire logic tx_clk,
	input wire logic rx_clk,
	input wire logic tx_en,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe_n,
	input wire logic strap_oe_n
);
	logic [7:0] low_ff;
	logic [7:0] up_ff;
	logic [5:0] pre_ff;
	logic mdc_ff;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Counts reset pin low time, time since its release and management clock rises.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_ff <= 8'h00;
			up_ff <= 8'h00;
			pre_ff <= 6'h00;
			mdc_ff <= 1'b0;
		end else begin
			low_ff <= rst_pin_n ? 8'h00 : low_ff + 8'(low_ff != 8'hFF);
			up_ff <= !rst_pin_n ? 8'h00 : up_ff + 8'(up_ff != 8'hFF);
			pre_ff <= mdio_oe_n ? 6'h00 : pre_ff + 6'(mdc && !mdc_ff);
			mdc_ff <= mdc;
		end
	end
	tx_clk_run_a: assert property (!strap_oe_n && !$past(strap_oe_n) |-> tx_clk != $past(tx_clk))
		else $error("transmit clock stopped");
	rx_clk_run_a: assert property (!strap_oe_n && !$past(strap_oe_n) |-> rx_clk != $past(rx_clk))
		else $error("receive clock stopped");
	pulse_len_a: assert property ($rose(rst_pin_n) |-> low_ff >= 8'd25)
		else $error("reset pulse too short");
	settle_a: assert property ($fell(mdio_oe_n) |-> up_ff >= 8'd75)
		else $error("preamble began too early");
	preamble_len_a: assert property ($rose(mdio_oe_n) |-> pre_ff == 6'd32)
		else $error("preamble length wrong");
	preamble_high_a: assert property (!mdio_oe_n |-> mdio_o)
		else $error("preamble not high");
	latch_wait_a: assert property ($fell(strap_oe_n) |-> up_ff >= 8'd75)
		else $error("straps taken too early");
	strap_hold_a: assert property ($fell(strap_oe_n) |=> !strap_oe_n [*8])
		else $error("strap drivers let go");
	strap_free_a: assert property ($fell(rst_pin_n) |-> ##[1:4] strap_oe_n)
		else $error("strap pins still driven in reset");
	tx_gate_a: assert property (tx_en |-> !strap_oe_n)
		else $error("transmit before straps taken");
	cover property ($rose(tx_en));
	cover property ($fell(strap_oe_n));
	cover property ($rose(mdio_oe_n));
endmodule : pmrl_chk

/* File: sim/tb_phy_mii_reset_latency_timing.sv */
// Purpose: Self-checking bench joining both ends through the link interface.
// Assumes: Power-up count shortened to 100 cycles.
// Notes: Drivers note expected nibbles in queues; monitors pop and compare.
`timescale 1ns/100ps
module tb_phy_mii_reset_latency_timing;
	import pmrl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic soft_reset = 1'b0;
	logic hw_reset_req = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	pmrl_nib_t tx_data = 4'h0;
	pmrl_strap_t strap_in = 5'h0A;
	pmrl_nib_t line_rx_data = 4'h0;
	pmrl_line_e line_rx_code = PMRL_LINE_IDLE;
	pmrl_strap_t strap_latched;
	logic strap_valid, rx_overflow, tx_ready, mgmt_ready, rx_valid, carrier;
	pmrl_nib_t line_tx_data, rx_data;
	pmrl_line_e line_tx_code;
	int n_errors = 0;
	int cmp_count = 0;
	pmrl_nib_t tx_q[$], rx_q[$];
	pmrl_if bus();
	pmrl_dev #(.PWRUP_CYC(100), .DEPTH(16)) u_pmrl_dev (.clk_sys(clk_sys), .rst(rst),
		.mii(bus), .soft_reset(soft_reset), .strap_in(strap_in),
		.strap_latched(strap_latched), .strap_valid(strap_valid), .line_tx_data(line_tx_data),
		.line_tx_code(line_tx_code), .line_rx_data(line_rx_data),
		.line_rx_code(line_rx_code), .rx_overflow(rx_overflow));
	pmrl_mac #(.PWRUP_CYC(100), .DEPTH(16)) u_pmrl_mac (.clk_sys(clk_sys), .rst(rst),
		.mii(bus), .hw_reset_req(hw_reset_req), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_last(tx_last), .mgmt_ready(mgmt_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .carrier(carrier));
	pmrl_chk u_pmrl_chk (.clk_sys(clk_sys), .rst(rst), .rst_pin_n(bus.rst_pin_n),
		.tx_clk(bus.tx_clk), .rx_clk(bus.rx_clk), .tx_en(bus.tx_en), .mdc(bus.mdc),
		.mdio_o(bus.mdio_o), .mdio_oe_n(bus.mdio_oe_n), .strap_oe_n(bus.strap_oe_n));
	// Makes the 25 MHz system clock.
	always #20 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Moves to the falling edge and ends the run if a wait runs out.
	task automatic tick(inout int n, input int lim);
		@(negedge clk_sys);
		n++;
		if (n >= lim) begin
			n_errors++;
			$display("ERROR wait ran out after %0d cycles", n);
			tally_and_finish();
		end
	endtask : tick
	task automatic step;
		@(posedge clk_sys);
		#2;
	endtask : step
	// Offers nibbles until refused or done; each is offered for one cycle and a refused one is dropped.
	// Ready only moves on the rising edge, so it is read at the falling edge before it.
	task automatic send_tx(input int cnt, output int took);
		took = 0;
		for (int i = 0; i < cnt; i++) begin
			@(posedge clk_sys);
			#2;
			tx_valid = 1'b1;
			tx_data = 4'($urandom);
			tx_last = (i == cnt - 1);
			@(negedge clk_sys);
			if (tx_ready !== 1'b1) break;
			tx_q.push_back(tx_data);
			took++;
		end
		@(posedge clk_sys);
		#2;
		tx_valid = 1'b0;
	endtask : send_tx
	// Follows one transmit frame on the line side.
	task automatic tx_frame;
		int n;
		n = 0;
		while (bus.tx_en !== 1'b1) tick(n, 3000);
		n = 0;
		while (line_tx_code !== PMRL_LINE_J) tick(n, 50);
		check("j_delay", 16'(n), 16'd3);
		while (line_tx_code !== PMRL_LINE_T) tick(n, 100);
		check("tx_left", 16'(tx_q.size()), 16'd0);
		tick(n, 200);
		check("after_t", 16'(line_tx_code), 16'(PMRL_LINE_IDLE));
	endtask : tx_frame
	// Sends one receive frame and times carrier sense on and off.
	task automatic rx_frame(input int len);
		int on;
		int n;
		on = 0;
		for (int i = 0; i < len; i++) begin
			line_rx_code = (i == 0) ? PMRL_LINE_J : PMRL_LINE_DATA;
			line_rx_data = 4'($urandom);
			rx_q.push_back(line_rx_data);
			@(negedge clk_sys);
			if (bus.crs === 1'b1 && on == 0) on = i;
			step();
		end
		check("crs_on", 16'(on), 16'd6);
		line_rx_code = PMRL_LINE_T;
		line_rx_data = ~line_rx_data;
		@(negedge clk_sys);
		check("carrier_on", 16'(carrier), 16'd1);
		n = 0;
		step();
		line_rx_code = PMRL_LINE_IDLE;
		line_rx_data = ~line_rx_data;
		while (bus.crs !== 1'b0) tick(n, 50);
		check("crs_off", 16'(n), 16'd7);
		// The controller's carrier trails the pin by its two sampling stages.
		step();
		step();
		check("carrier_off", 16'(carrier), 16'd0);
	endtask : rx_frame
	// Pairs each line nibble and each received nibble with the oldest note.
	always @(negedge clk_sys) begin
		// Each transmit nibble stands two cycles on the line; it is looked at in the first.
		if (bus.tx_clk === 1'b1 && line_tx_code inside {PMRL_LINE_J, PMRL_LINE_DATA}) begin
			check("line_tx", 16'(line_tx_data), tx_q.size() ? 16'(tx_q.pop_front()) : 16'hFF);
		end
		if (rx_valid === 1'b1) begin
			check("rx_data", 16'(rx_data), rx_q.size() ? 16'(rx_q.pop_front()) : 16'hFF);
		end
	end
	initial begin
		#800000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		int n;
		int took;
		void'($urandom(32323));
		repeat (5) @(posedge clk_sys);
		#2 rst = 1'b0;
		// The buffer fills and refuses before the link is up, then drains as one frame.
		fork
			tx_frame();
			send_tx(40, took);
		join
		check("fill", 16'(took), 16'd16);
		check("straps", 16'(strap_latched), 16'(strap_in));
		check("strap_drive", 16'(bus.strap_oe_n), 16'd0);
		check("strap_pins", 16'(bus.strap_o), 16'(strap_in));
		@(posedge clk_sys);
		fork
			tx_frame();
			send_tx(3 + int'($urandom % 6), took);
		join
		step();
		rx_frame(8);
		rx_frame(8 + int'($urandom % 9));
		// Software reset drops and retakes the straps.
		strap_in = 5'($urandom);
		soft_reset = 1'b1;
		repeat (3) @(posedge clk_sys);
		#2 soft_reset = 1'b0;
		check("drop", 16'(strap_valid), 16'd0);
		n = 0;
		while (strap_valid !== 1'b1) tick(n, 400);
		check("relatch", 16'(n >= 75), 16'd1);
		check("straps", 16'(strap_latched), 16'(strap_in));
		// Hardware reset from the controller reruns the start-up from the reset pulse.
		step();
		strap_in = 5'($urandom);
		hw_reset_req = 1'b1;
		step();
		hw_reset_req = 1'b0;
		n = 0;
		while (mgmt_ready !== 1'b0) tick(n, 20);
		n = 0;
		while (mgmt_ready !== 1'b1) tick(n, 3000);
		check("straps", 16'(strap_latched), 16'(strap_in));
		check("strap_pins", 16'(bus.strap_o), 16'(strap_in));
		step();
		rx_frame(12);
		n = 0;
		while (rx_q.size() > 0) tick(n, 100);
		check("overflow", 16'(rx_overflow), 16'd0);
		tally_and_finish();
	end
endmodule : tb_phy_mii_reset_latency_timing
